// *** core/ssre_engine.v ***
// ssre_engine.v: scan compare engine and four-drive seek/recalibrate stepper
// assumes 20 MHz, same-clock read logic, and pin-level drive and count lines
//
// What this block does
// - each disk byte compared with its host byte per scan variant
// - byte FF on either side always satisfies
// - unsigned compare, 00 smallest, FF largest
// - unmatched sector: sector number plus stride, scan goes on
// - scan stops on a satisfied sector, after final sector, or on terminal count
// - satisfied sector with every byte equal sets scan hit, status 2 bit 3
// - none satisfied through final sector: scan miss, status 2 bit 2
// - terminal count ends scan once current byte is compared
// - hit only if equal; wrong direction or unequal in equal scan: miss
// - deleted mark, no bypass: last sector, control mark, end
// - deleted mark with bypass: skip sector, still control mark
// - stride 01 scans contiguous sectors, 02 alternate ones
// - host byte later than 27/13 us: overrun, abnormal end
// - four present cylinders, cleared only by recalibrate
// - below target step in, direction 1; above, out with 0
// - steps spaced by step interval; arrival sets seek end, interrupt
// - per-drive busy bits set while seeking, cleared only by sense
// - seeks may overlap; host sends nothing else while stepping
// - drive not ready at start or while positioning: not ready, abnormal end
// - first step gap may be short by up to one millisecond
// - recalibrate zeroes cylinder, steps out until track 0 high, seek end
// - track 0 low after 256 steps: seek end, fault, abnormal end
// - step interval F is 1 ms, E is 2 ms, down to 16 ms
// - sense clears interrupt, reports its cause in status 0 bits 7:5
`timescale 1ns/1ps
`include "ssre_defs.vh"

module ssre_engine
#(
  parameter MS_CYCLES = `SSRE_MS_CYCLES
)
(
  input wire clock,
  input wire reset_n,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [7:0] disk_byte,
  input wire disk_byte_valid,
  input wire disk_sector_start,
  input wire disk_deleted_mark,
  input wire disk_sector_end,
  input wire [7:0] host_byte,
  input wire host_byte_valid,
  output wire host_req,
  input wire terminal_count,
  output reg [7:0] scan_sector,
  output wire scan_active,
  input wire [3:0] drive_ready,
  input wire [3:0] drive_track0,
  output wire [3:0] drive_step,
  output wire [3:0] drive_direction,
  output reg irq
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  // pin synchronisers for terminal count
  reg tc_m_q;
  reg tc_s_q;
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tc_m_q <= 1'b0;
      tc_s_q <= 1'b0;
    end
    else
    begin
      tc_m_q <= terminal_count;
      tc_s_q <= tc_m_q;
    end
  end

  // free-running ms tick; the first step gap may fall short by one tick
  reg [15:0] ms_cnt_q;
  wire ms_tick = (ms_cnt_q == 16'h0000);
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ms_cnt_q <= 16'h0000;
    else if (ms_tick)
      ms_cnt_q <= MS_CYCLES[15:0] - 16'h0001;
    else
      ms_cnt_q <= ms_cnt_q - 16'h0001;
  end

  // register decode strobes
  wire wr_ctrl = reg_wr && (reg_addr == `SSRE_A_CTRL);
  wire wr_sector = reg_wr && (reg_addr == `SSRE_A_SECTOR);
  wire wr_poscmd = reg_wr && (reg_addr == `SSRE_A_POSCMD);
  wire rd_sense = reg_rd && (reg_addr == `SSRE_A_SENSE);

  // software settings
  reg [7:0] final_sector_number;
  reg [7:0] sector_stride;
  reg [3:0] step_interval;
  reg [7:0] target_cylinder;
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      final_sector_number <= 8'h00;
      sector_stride <= `SSRE_RST_STRIDE;
      step_interval <= `SSRE_RST_STEP_INTERVAL;
      target_cylinder <= 8'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SSRE_A_FINAL: final_sector_number <= reg_wdata;
        `SSRE_A_STRIDE: sector_stride <= reg_wdata;
        `SSRE_A_SPECIFY: step_interval <= reg_wdata[3:0];
        `SSRE_A_TARGET: target_cylinder <= reg_wdata;
        default: ;
      endcase
    end
  end

  // step gap in ms: F gives 1, E gives 2, 0 gives 16
  wire [4:0] gap_ms = 5'h10 - {1'b0, step_interval};

  // scan engine
  reg [1:0] scan_state_q;
  reg [1:0] variant_q;
  reg deleted_bypass;
  reg mfm_q;
  reg [1:0] scan_drv_q;
  reg [7:0] disk_hold_q;
  reg pend_q;
  reg [9:0] wait_q;
  reg sec_ok_q;
  reg sec_eq_q;
  reg del_q;
  reg end_q;
  reg tc_seen_q;
  reg scan_hit_flag;
  reg scan_miss_flag;
  reg control_mark_flag;
  reg overrun_q;
  reg scan_nr_q;
  reg [1:0] scan_code_q;
  wire [3:0] rdy_s;

  wire run = scan_state_q[1];
  assign scan_active = run;
  assign host_req = run && pend_q;

  // unsigned byte compare with FF acting as a wildcard
  wire mask = (disk_hold_q == `SSRE_MASK_BYTE) || (host_byte == `SSRE_MASK_BYTE);
  wire b_eq = mask || (disk_hold_q == host_byte);
  wire b_le = mask || (disk_hold_q <= host_byte);
  wire b_ge = mask || (disk_hold_q >= host_byte);
  reg b_sat;
  always @*
  begin
    case (variant_q)
      `SSRE_VAR_LE: b_sat = b_le;
      `SSRE_VAR_GE: b_sat = b_ge;
      default: b_sat = b_eq;
    endcase
  end

  wire [31:0] lim_fm = `SSRE_FM_LIMIT_CYC;
  wire [31:0] lim_mfm = `SSRE_MFM_LIMIT_CYC;
  wire [9:0] limit = mfm_q ? lim_mfm[9:0] : lim_fm[9:0];
  wire take = pend_q && host_byte_valid;
  wire last_sec = (scan_sector == final_sector_number);
  wire start_scan = wr_ctrl && reg_wdata[`SSRE_CTRL_START] && !run;

  // scan sequencing; earliest stop wins
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scan_state_q <= ST_IDLE;
      variant_q <= `SSRE_VAR_EQ;
      deleted_bypass <= 1'b0;
      mfm_q <= 1'b0;
      scan_drv_q <= 2'h0;
      scan_sector <= 8'h00;
      disk_hold_q <= 8'h00;
      pend_q <= 1'b0;
      wait_q <= 10'h000;
      sec_ok_q <= 1'b1;
      sec_eq_q <= 1'b1;
      del_q <= 1'b0;
      end_q <= 1'b0;
      tc_seen_q <= 1'b0;
      scan_hit_flag <= 1'b0;
      scan_miss_flag <= 1'b0;
      control_mark_flag <= 1'b0;
      overrun_q <= 1'b0;
      scan_nr_q <= 1'b0;
      scan_code_q <= `SSRE_CODE_NORMAL;
    end
    else
    begin
      if (wr_sector && !run)
        scan_sector <= reg_wdata;
      case (scan_state_q)
        ST_IDLE:
        begin
          if (start_scan)
          begin
            variant_q <= reg_wdata[`SSRE_CTRL_VAR_LSB +: 2];
            deleted_bypass <= reg_wdata[`SSRE_CTRL_BYPASS];
            mfm_q <= reg_wdata[`SSRE_CTRL_MFM];
            scan_drv_q <= reg_wdata[`SSRE_CTRL_DRV_LSB +: 2];
            scan_hit_flag <= 1'b0;
            scan_miss_flag <= 1'b0;
            control_mark_flag <= 1'b0;
            overrun_q <= 1'b0;
            pend_q <= 1'b0;
            end_q <= 1'b0;
            tc_seen_q <= 1'b0;
            sec_ok_q <= 1'b1;
            sec_eq_q <= 1'b1;
            del_q <= 1'b0;
            if (!rdy_s[reg_wdata[`SSRE_CTRL_DRV_LSB +: 2]])
            begin
              scan_nr_q <= 1'b1;
              scan_code_q <= `SSRE_CODE_ABNORMAL;
            end
            else
            begin
              scan_nr_q <= 1'b0;
              scan_code_q <= `SSRE_CODE_NORMAL;
              scan_state_q <= ST_RUN;
            end
          end
        end
        ST_RUN:
        begin
          if (tc_s_q)
            tc_seen_q <= 1'b1;
          if (disk_sector_start)
          begin
            del_q <= disk_deleted_mark;
            sec_ok_q <= 1'b1;
            sec_eq_q <= 1'b1;
          end
          if (disk_sector_end)
            end_q <= 1'b1;
          if (disk_byte_valid)
          begin
            disk_hold_q <= disk_byte;
            pend_q <= 1'b1;
            wait_q <= 10'h000;
          end
          if (pend_q && !take)
            wait_q <= wait_q + 10'h001;
          if (pend_q && !take && (wait_q == limit - 10'h001))
          begin
            overrun_q <= 1'b1;
            scan_code_q <= `SSRE_CODE_ABNORMAL;
            pend_q <= 1'b0;
            scan_state_q <= ST_IDLE;
          end
          else if (take)
          begin
            pend_q <= disk_byte_valid;
            if (!b_sat)
              sec_ok_q <= 1'b0;
            if (!b_eq)
              sec_eq_q <= 1'b0;
            if (tc_seen_q || tc_s_q)
              scan_state_q <= ST_IDLE;
          end
          else if (tc_seen_q && !pend_q)
            scan_state_q <= ST_IDLE;
          else if (end_q && !pend_q)
          begin
            end_q <= 1'b0;
            sec_ok_q <= 1'b1;
            sec_eq_q <= 1'b1;
            if (del_q)
              control_mark_flag <= 1'b1;
            if (del_q && !deleted_bypass)
            begin
              // deleted sector counts as the last one
              scan_hit_flag <= sec_ok_q && sec_eq_q;
              scan_miss_flag <= !sec_ok_q;
              scan_state_q <= ST_IDLE;
            end
            else if (sec_ok_q && !del_q)
            begin
              scan_hit_flag <= sec_eq_q;
              scan_state_q <= ST_IDLE;
            end
            else if (last_sec)
            begin
              scan_miss_flag <= 1'b1;
              scan_state_q <= ST_IDLE;
            end
            else
              scan_sector <= scan_sector + sector_stride;
          end
        end
        default: scan_state_q <= ST_IDLE;
      endcase
    end
  end

  // positioning, one unit per drive
  wire [3:0] busy_all;
  wire [3:0] done_pend;
  wire [3:0] rchg_pend;
  wire [3:0] stepping;
  wire [31:0] pcn_all;
  wire [23:0] st0_all;
  wire [3:0] sense_clr;
  reg [1:0] sel;
  reg sel_valid;
  reg sel_rchg;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_drv
      reg rdy_m_q;
      reg rdy_q;
      reg t0_m_q;
      reg t0_q;
      reg act_q;
      reg recal_q;
      reg step_q;
      reg dir_q;
      reg [4:0] gap_q;
      reg [8:0] cnt_q;
      reg [7:0] tgt_q;
      reg [7:0] present_cylinder;
      reg busy_q;
      reg pend_q;
      reg [1:0] code_q;
      reg se_q;
      reg ec_q;
      reg nr_q;
      reg rdy_prev_q;
      reg rchg_q;
      wire go = wr_poscmd && (reg_wdata[1:0] == i);

      // ready and track 0 arrive from the drive cable
      always @(posedge clock or negedge reset_n)
      begin
        if (!reset_n)
        begin
          rdy_m_q <= 1'b0;
          rdy_q <= 1'b0;
          t0_m_q <= 1'b0;
          t0_q <= 1'b0;
        end
        else
        begin
          rdy_m_q <= drive_ready[i];
          rdy_q <= rdy_m_q;
          t0_m_q <= drive_track0[i];
          t0_q <= t0_m_q;
        end
      end

      // stepper, acts once per ms tick
      always @(posedge clock or negedge reset_n)
      begin
        if (!reset_n)
        begin
          act_q <= 1'b0;
          recal_q <= 1'b0;
          step_q <= 1'b0;
          dir_q <= 1'b0;
          gap_q <= 5'h00;
          cnt_q <= 9'h000;
          tgt_q <= 8'h00;
          present_cylinder <= 8'h00;
          busy_q <= 1'b0;
          pend_q <= 1'b0;
          code_q <= `SSRE_CODE_NORMAL;
          se_q <= 1'b0;
          ec_q <= 1'b0;
          nr_q <= 1'b0;
          rdy_prev_q <= 1'b0;
          rchg_q <= 1'b0;
        end
        else
        begin
          step_q <= 1'b0;
          rdy_prev_q <= rdy_q;
          if (rdy_q != rdy_prev_q)
            rchg_q <= 1'b1;
          else if (sense_clr[i] && sel_rchg)
            rchg_q <= 1'b0;
          if (sense_clr[i] && !sel_rchg)
          begin
            pend_q <= 1'b0;
            busy_q <= 1'b0;
          end
          if (go && !act_q)
          begin
            busy_q <= 1'b1;
            recal_q <= reg_wdata[`SSRE_POSCMD_RECAL];
            tgt_q <= target_cylinder;
            gap_q <= 5'h00;
            cnt_q <= 9'h000;
            se_q <= 1'b0;
            ec_q <= 1'b0;
            nr_q <= 1'b0;
            if (reg_wdata[`SSRE_POSCMD_RECAL])
            begin
              present_cylinder <= 8'h00;
              dir_q <= 1'b0;
            end
            if (!rdy_q)
            begin
              nr_q <= 1'b1;
              se_q <= 1'b1;
              code_q <= `SSRE_CODE_ABNORMAL;
              pend_q <= 1'b1;
            end
            else
              act_q <= 1'b1;
          end
          else if (act_q && ms_tick)
          begin
            if (!rdy_q)
            begin
              nr_q <= 1'b1;
              se_q <= 1'b1;
              code_q <= `SSRE_CODE_ABNORMAL;
              pend_q <= 1'b1;
              act_q <= 1'b0;
            end
            else if (gap_q > 5'h01)
              gap_q <= gap_q - 5'h01;
            else if (recal_q && t0_q)
            begin
              se_q <= 1'b1;
              code_q <= `SSRE_CODE_NORMAL;
              pend_q <= 1'b1;
              act_q <= 1'b0;
            end
            else if (recal_q && (cnt_q == `SSRE_RECAL_MAX_STEPS))
            begin
              se_q <= 1'b1;
              ec_q <= 1'b1;
              code_q <= `SSRE_CODE_ABNORMAL;
              pend_q <= 1'b1;
              act_q <= 1'b0;
            end
            else if (!recal_q && (present_cylinder == tgt_q))
            begin
              se_q <= 1'b1;
              code_q <= `SSRE_CODE_NORMAL;
              pend_q <= 1'b1;
              act_q <= 1'b0;
            end
            else
            begin
              step_q <= 1'b1;
              gap_q <= gap_ms;
              cnt_q <= cnt_q + 9'h001;
              if (recal_q)
                dir_q <= 1'b0;
              else if (present_cylinder < tgt_q)
              begin
                dir_q <= 1'b1;
                present_cylinder <= present_cylinder + 8'h01;
              end
              else
              begin
                dir_q <= 1'b0;
                present_cylinder <= present_cylinder - 8'h01;
              end
            end
          end
        end
      end

      assign drive_step[i] = step_q;
      assign drive_direction[i] = dir_q;
      assign busy_all[i] = busy_q;
      assign done_pend[i] = pend_q;
      assign rchg_pend[i] = rchg_q;
      assign stepping[i] = act_q;
      assign pcn_all[i*8 +: 8] = present_cylinder;
      assign st0_all[i*6 +: 6] = {code_q, se_q, ec_q, nr_q, 1'b0};
      assign rdy_s[i] = rdy_q;
      assign sense_clr[i] = rd_sense && sel_valid && (sel == i);
    end
  endgenerate

  // sense serves the lowest finished drive first, then ready changes
  always @*
  begin
    sel = 2'h0;
    sel_valid = 1'b0;
    sel_rchg = 1'b0;
    if (done_pend[0] || done_pend[1] || done_pend[2] || done_pend[3])
    begin
      sel_valid = 1'b1;
      sel = done_pend[0] ? 2'h0 : done_pend[1] ? 2'h1 : done_pend[2] ? 2'h2 : 2'h3;
    end
    else if (rchg_pend != 4'h0)
    begin
      sel_valid = 1'b1;
      sel_rchg = 1'b1;
      sel = rchg_pend[0] ? 2'h0 : rchg_pend[1] ? 2'h1 : rchg_pend[2] ? 2'h2 : 2'h3;
    end
  end

  // interrupt while an end or ready change is unsensed
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= ((done_pend & ~sense_clr) != 4'h0) ||
             ((rchg_pend & ~sense_clr) != 4'h0);
  end

  // read port, one cycle late; sense reads have side effects
  reg [7:0] sense_pcn_q;
  reg [7:0] sense_st0;
  always @*
  begin
    sense_st0 = `SSRE_INVALID_ST0;
    if (sel_valid && sel_rchg)
      sense_st0 = {`SSRE_CODE_READY_CHG, 4'h0, sel};
    else if (sel_valid)
      sense_st0 = {st0_all[sel*6 +: 6], sel};
  end

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 8'h00;
      sense_pcn_q <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `SSRE_A_CTRL: reg_rdata <= {scan_drv_q, 1'b0, mfm_q, deleted_bypass, run, variant_q};
        `SSRE_A_SECTOR: reg_rdata <= scan_sector;
        `SSRE_A_FINAL: reg_rdata <= final_sector_number;
        `SSRE_A_STRIDE: reg_rdata <= sector_stride;
        `SSRE_A_SCAN_ST: reg_rdata <= {1'b0, control_mark_flag, 1'b0, overrun_q,
                                       scan_hit_flag, scan_miss_flag, 2'h0};
        `SSRE_A_SCAN_ST0: reg_rdata <= {scan_code_q, 1'b0, 1'b0, scan_nr_q, 1'b0, scan_drv_q};
        `SSRE_A_SPECIFY: reg_rdata <= {4'h0, step_interval};
        `SSRE_A_TARGET: reg_rdata <= target_cylinder;
        `SSRE_A_SENSE:
        begin
          reg_rdata <= sense_st0;
          sense_pcn_q <= pcn_all[sel*8 +: 8];
        end
        `SSRE_A_SENSE_PCN: reg_rdata <= sense_pcn_q;
        // stepping tells the host to hold off other commands
        `SSRE_A_MAIN_ST: reg_rdata <= {1'b0, irq, (stepping != 4'h0), run, busy_all};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // ssre_engine

// *** core/ssre_defs.vh ***
// offsets, field positions, reset values and timing counts
// shared by the engine; definitions only, no logic
`ifndef SSRE_DEFS_VH
`define SSRE_DEFS_VH

// clock and time units
`define SSRE_CLK_MHZ 20
`define SSRE_MS_IN_US 1000
`define SSRE_MS_CYCLES (`SSRE_MS_IN_US * `SSRE_CLK_MHZ)
// host byte deadlines
`define SSRE_FM_LIMIT_US 27
`define SSRE_MFM_LIMIT_US 13
`define SSRE_FM_LIMIT_CYC (`SSRE_FM_LIMIT_US * `SSRE_CLK_MHZ)
`define SSRE_MFM_LIMIT_CYC (`SSRE_MFM_LIMIT_US * `SSRE_CLK_MHZ)
// recalibrate step limit
`define SSRE_RECAL_MAX_STEPS 9'h100

// register offsets (4-bit address, 8-bit data)
`define SSRE_A_CTRL 4'h0
`define SSRE_A_SECTOR 4'h1
`define SSRE_A_FINAL 4'h2
`define SSRE_A_STRIDE 4'h3
`define SSRE_A_SCAN_ST 4'h4
`define SSRE_A_SCAN_ST0 4'h5
`define SSRE_A_SPECIFY 4'h6
`define SSRE_A_TARGET 4'h7
`define SSRE_A_POSCMD 4'h8
`define SSRE_A_SENSE 4'h9
`define SSRE_A_SENSE_PCN 4'hA
`define SSRE_A_MAIN_ST 4'hB

// control and position command register fields
`define SSRE_CTRL_VAR_LSB 0
`define SSRE_CTRL_BYPASS 2
`define SSRE_CTRL_MFM 3
`define SSRE_CTRL_START 4
`define SSRE_CTRL_DRV_LSB 5
`define SSRE_POSCMD_RECAL 2

// scan variants
`define SSRE_VAR_EQ 2'h0
`define SSRE_VAR_LE 2'h1
`define SSRE_VAR_GE 2'h2

// status bit positions
`define SSRE_ST2_CM 6
`define SSRE_ST2_HIT 3
`define SSRE_ST2_MISS 2
`define SSRE_ST1_OVR 4
`define SSRE_ST0_SE 5
`define SSRE_ST0_EC 4
`define SSRE_ST0_NR 3

// termination codes (status 0 bits 7:6)
`define SSRE_CODE_NORMAL 2'h0
`define SSRE_CODE_ABNORMAL 2'h1
`define SSRE_CODE_READY_CHG 2'h3
`define SSRE_INVALID_ST0 8'h80

// reset values and wildcard byte
`define SSRE_RST_STRIDE 8'h01
`define SSRE_RST_STEP_INTERVAL 4'hF
`define SSRE_MASK_BYTE 8'hFF

`endif

// *** testbench/ssre_engine_properties.sv ***
// port timing checks for the scan/seek engine
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
module ssre_checker (
  input wire clock,
  input wire reset_n,
  input wire reg_rd,
  input wire reg_wr,
  input wire disk_byte_valid,
  input wire disk_deleted_mark,
  input wire host_byte_valid,
  input wire host_req,
  input wire scan_active,
  input wire [7:0] scan_sector,
  input wire [3:0] drive_step,
  input wire irq
);
  reg [9:0] wait_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // host wait length
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      wait_q <= 10'h000;
    else
      wait_q <= host_req ? wait_q + 10'h001 : 10'h000;
  end
  a_req_rise: assert property (disk_byte_valid && scan_active && !disk_deleted_mark |=> host_req)
    else $error("no host request");
  a_req_fall: assert property (host_req && host_byte_valid && !disk_byte_valid |=> !host_req)
    else $error("host request stuck");
  a_req_bound: assert property (wait_q <= 10'h21C)
    else $error("request past overrun");
  a_step_single: assert property (|drive_step |=> (drive_step & $past(drive_step)) == 4'h0)
    else $error("step pulse too wide");
  a_step_gap: assert property ($rose(drive_step[0]) |=> !drive_step[0] [*8])
    else $error("step pulses too close");
  a_scan_off: assert property (!scan_active && !reg_wr |=> !scan_active)
    else $error("scan restarted");
  a_sector_stride: assert property (scan_active && $past(scan_active)
    && scan_sector != $past(scan_sector) |-> scan_sector - $past(scan_sector) <= 8'h02)
    else $error("sector jump too big");
  a_irq_holds: assert property (irq && !reg_rd && !$past(reg_rd) |=> irq)
    else $error("irq dropped early");
  cover property (|drive_step);
  cover property ($fell(scan_active));
  cover property ($fell(irq));
endmodule // ssre_checker

// *** testbench/ssre_drive_model.sv ***
// four head positioners answering step and direction
// assumes one-cycle step pulses; stuck keeps track 0 low to force a fault
`timescale 1ns/1ps
module ssre_drive_model (
  input wire clock,
  input wire [3:0] step,
  input wire [3:0] dir,
  input wire [3:0] stuck,
  output reg [3:0] track0
);
  reg [7:0] pos [0:3];
  reg [8:0] n [0:3];
  reg [3:0] lastdir;
  integer i, j;
  // heads start off track 0 so recalibrate must step
  initial
  begin
    lastdir = 4'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      pos[i] = 8'h05;
      n[i] = 9'h000;
    end
  end
  // move one cylinder per pulse, never below zero
  always @(posedge clock)
  begin
    for (i = 0; i < 4; i = i + 1)
      if (step[i])
      begin
        pos[i] <= dir[i] ? pos[i] + 8'h01 : (pos[i] == 8'h00 ? 8'h00 : pos[i] - 8'h01);
        n[i] <= n[i] + 9'h001;
        lastdir[i] <= dir[i];
      end
  end
  // sensor only high at cylinder zero
  always @*
  begin
    for (j = 0; j < 4; j = j + 1)
      track0[j] = pos[j] == 8'h00 && !stuck[j];
  end
endmodule // ssre_drive_model

// *** testbench/ssre_engine_tb_top.sv ***
// directed scenarios for scan, seek and recalibrate
// assumes the engine with short millisecond count and the drive model
`timescale 1ns/1ps
module ssre_engine_tb_top;
  reg clock, reset_n, reg_wr, reg_rd, disk_byte_valid, disk_sector_start;
  reg disk_deleted_mark, disk_sector_end, host_byte_valid, terminal_count;
  reg [3:0] reg_addr, drive_ready, stuck;
  reg [7:0] reg_wdata, disk_byte, host_byte, rv;
  wire [7:0] reg_rdata, scan_sector;
  wire [3:0] drive_step, drive_direction, drive_track0;
  wire host_req, scan_active, irq;
  integer errors, checks, k;
  reg [33:0] tv [0:7];
  ssre_engine #(.MS_CYCLES(20)) dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .disk_byte(disk_byte), .disk_byte_valid(disk_byte_valid),
    .disk_sector_start(disk_sector_start), .disk_deleted_mark(disk_deleted_mark),
    .disk_sector_end(disk_sector_end), .host_byte(host_byte),
    .host_byte_valid(host_byte_valid), .host_req(host_req),
    .terminal_count(terminal_count), .scan_sector(scan_sector), .scan_active(scan_active),
    .drive_ready(drive_ready), .drive_track0(drive_track0), .drive_step(drive_step),
    .drive_direction(drive_direction), .irq(irq));
  ssre_drive_model dm (.clock(clock), .step(drive_step), .dir(drive_direction),
    .stuck(stuck), .track0(drive_track0));
  task summarize;
  begin
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
  begin
    checks = checks + 1;
    if (e !== g)
    begin
      errors = errors + 1;
      $display("ERROR %0s expected %h got %h", nm, e, g);
    end
  end
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  end
  endtask
  // bounded wait: 1 scan over, 2 interrupt
  task waitc(input integer s);
    integer i;
  begin
    i = 0;
    while (!(s == 1 ? scan_active === 1'b0 : irq === 1'b1))
    begin
      @(posedge clock);
      #1 i = i + 1;
      if (i > 8000)
      begin
        errors = errors + 1;
        summarize;
      end
    end
  end
  endtask
  // one single-byte sector; srv 0 withholds the host byte and the end
  task sec(input [7:0] d, input [7:0] h, input del, input srv);
  begin
    @(posedge clock);
    disk_sector_start <= 1'b1;
    disk_deleted_mark <= del;
    @(posedge clock);
    disk_sector_start <= 1'b0;
    disk_byte <= d;
    disk_byte_valid <= 1'b1;
    @(posedge clock);
    disk_byte_valid <= 1'b0;
    @(posedge clock);
    if (srv && host_req === 1'b1)
    begin
      host_byte <= h;
      host_byte_valid <= 1'b1;
      @(posedge clock);
      host_byte_valid <= 1'b0;
    end
    @(posedge clock);
    disk_sector_end <= srv;
    @(posedge clock);
    disk_sector_end <= 1'b0;
    repeat (4) @(posedge clock);
  end
  endtask
  task go(input [7:0] r, input [7:0] f, input [7:0] s, input [7:0] c);
  begin
    wr(4'h1, r);
    wr(4'h2, f);
    wr(4'h3, s);
    wr(4'h0, c | 8'h10);
  end
  endtask
  task t_compare;
  begin
    for (k = 0; k < 8; k = k + 1)
    begin
      go(8'h01, 8'h01, 8'h01, {6'h00, tv[k][33:32]});
      sec(tv[k][31:24], tv[k][23:16], 1'b0, 1'b1);
      waitc(1);
      rd(4'h4);
      chk("compare", tv[k][15:8], rv & tv[k][7:0]);
    end
  end
  endtask
  task t_stride;
  begin
    go(8'h01, 8'h05, 8'h02, 8'h00);
    for (k = 0; k < 3; k = k + 1)
    begin
      chk("sector", 8'h01 + 2 * k, scan_sector);
      sec(8'h11, 8'h22, 1'b0, 1'b1);
    end
    waitc(1);
    rd(4'h4);
    chk("miss", 8'h04, rv & 8'h0C);
  end
  endtask
  task t_deleted;
  begin
    go(8'h01, 8'h03, 8'h01, 8'h00);
    sec(8'h11, 8'h22, 1'b1, 1'b1);
    waitc(1);
    rd(4'h4);
    chk("mark stop", 8'h44, rv & 8'h44);
    chk("sector", 8'h01, scan_sector);
    go(8'h01, 8'h03, 8'h01, 8'h04);
    sec(8'h11, 8'h11, 1'b1, 1'b1);
    sec(8'h33, 8'h33, 1'b0, 1'b1);
    waitc(1);
    rd(4'h4);
    chk("mark skip", 8'h48, rv & 8'h4C);
    chk("sector", 8'h02, scan_sector);
  end
  endtask
  task t_tc_overrun;
  begin
    go(8'h01, 8'h03, 8'h01, 8'h00);
    @(posedge clock);
    terminal_count <= 1'b1;
    sec(8'h11, 8'h22, 1'b0, 1'b1);
    waitc(1);
    terminal_count <= 1'b0;
    rd(4'h4);
    chk("tc flags", 8'h00, rv & 8'h0C);
    chk("sector", 8'h01, scan_sector);
    go(8'h01, 8'h01, 8'h01, 8'h08);
    sec(8'h11, 8'h22, 1'b0, 1'b0);
    waitc(1);
    rd(4'h4);
    chk("overrun", 8'h10, rv & 8'h10);
    rd(4'h5);
    chk("code", 8'h40, rv & 8'hC0);
    go(8'h01, 8'h01, 8'h01, 8'h60);
    rd(4'h5);
    chk("scan nr", 8'h4B, rv);
  end
  endtask
  // recalibrate, seek in, seek out, then recalibrate and not-ready faults
  task t_position;
  begin
    wr(4'h6, 8'h0F);
    wr(4'h8, 8'h04);
    waitc(2);
    rd(4'h9);
    chk("recal", 8'h20, rv);
    chk("pos", 8'h00, dm.pos[0]);
    for (k = 0; k < 2; k = k + 1)
    begin
      wr(4'h7, k ? 8'h02 : 8'h08);
      wr(4'h8, 8'h00);
      waitc(2);
      chk("pos", k ? 8'h02 : 8'h08, dm.pos[0]);
      chk("dir", k ? 1'b0 : 1'b1, dm.lastdir[0]);
      rd(4'hB);
      chk("busy", 8'h01, rv & 8'h01);
      rd(4'h9);
      chk("sense", 8'h20, rv);
      rd(4'hA);
      chk("cyl", k ? 8'h02 : 8'h08, rv);
      rd(4'hB);
      chk("busy", 8'h00, rv & 8'h01);
    end
    stuck <= 4'h2;
    wr(4'h8, 8'h05);
    waitc(2);
    rd(4'h9);
    chk("fault", 8'h71, rv);
    chk("steps", 9'h100, dm.n[1]);
    wr(4'h8, 8'h03);
    waitc(2);
    rd(4'h9);
    chk("not ready", 8'h6B, rv);
    chk("irq", 1'b0, irq);
  end
  endtask
  initial
  begin
    {clock, reset_n, reg_wr, reg_rd, disk_byte_valid, disk_sector_start} = 6'h00;
    {disk_deleted_mark, disk_sector_end, host_byte_valid, terminal_count} = 4'h0;
    {reg_addr, reg_wdata, disk_byte, host_byte, stuck} = 32'h0;
    drive_ready = 4'h7;
    errors = 0;
    checks = 0;
    tv = '{{2'h0, 8'h55, 8'h55, 8'h08, 8'h0C}, {2'h0, 8'h55, 8'h56, 8'h04, 8'h0C},
      {2'h1, 8'h03, 8'h09, 8'h00, 8'h0C}, {2'h1, 8'h09, 8'h03, 8'h04, 8'h0C},
      {2'h2, 8'h80, 8'h7F, 8'h00, 8'h0C}, {2'h2, 8'h03, 8'h09, 8'h04, 8'h0C},
      {2'h1, 8'hFF, 8'h00, 8'h00, 8'h04}, {2'h2, 8'h00, 8'hFF, 8'h00, 8'h04}};
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    // ready pins high at reset raise change events; sense them away
    repeat (6) @(posedge clock);
    repeat (4) rd(4'h9);
    chk("idle sense", 8'h80, rv);
    t_compare;
    t_stride;
    t_deleted;
    t_tc_overrun;
    t_position;
    summarize;
  end
  initial
  begin
    forever #25 clock = ~clock;
  end
endmodule // ssre_engine_tb_top
bind ssre_engine ssre_checker u_chk (.clock(clock), .reset_n(reset_n), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .disk_byte_valid(disk_byte_valid), .disk_deleted_mark(disk_deleted_mark),
  .host_byte_valid(host_byte_valid), .host_req(host_req), .scan_active(scan_active),
  .scan_sector(scan_sector), .drive_step(drive_step), .irq(irq));
